/* File: meter_pkg.sv */
// shared constants, types and helpers for the flow totalizer
package meter_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	// register offsets
	localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
	localparam logic [AW-1:0] OFF_CALRES = 8'h04;
	localparam logic [AW-1:0] OFF_STATUS = 8'h08;
	localparam logic [AW-1:0] OFF_BATCH  = 8'h0C;
	localparam logic [AW-1:0] OFF_CUMUL  = 8'h10;
	localparam logic [AW-1:0] OFF_RATE   = 8'h14;
	localparam logic [AW-1:0] OFF_KFAC   = 8'h18;
	localparam logic [AW-1:0] OFF_KFLD   = 8'h1C;
	// control field positions
	localparam int CTRL_BYPASS = 0;
	localparam int CTRL_RATE   = 1;
	localparam int CTRL_CAL    = 2;
	// calibration result field positions
	localparam int CALRES_PASS = 0;
	localparam int CALRES_FAIL = 1;
	// reset values
	localparam logic [2:0]  CTRL_RST = 3'h0;
	localparam logic [15:0] KFAC_RST = 16'h0064;
	localparam logic [15:0] KFLD_RST = 16'h0064;
	localparam logic [23:0] BCD_ZERO = 24'h00_0000;
	localparam logic [23:0] BCD_ONE  = 24'h00_0001;
	// timing
	localparam int CLK_HZ      = 125_000_000;
	localparam int TICK_MS     = 10;
	localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int HOLD_S      = 3;
	localparam int OFF_S       = 240;
	localparam int BYPASS_S    = 180;
	localparam int RATE_S      = 60;
	localparam int PROP_MS     = 1000;
	localparam int BLINK_MS    = 500;
	localparam logic [15:0] HOLD_TICKS  = 16'(HOLD_S * 1000 / TICK_MS);
	localparam logic [15:0] OFF_TICKS   = 16'(OFF_S * 1000 / TICK_MS);
	localparam logic [15:0] BYP_TICKS   = 16'(BYPASS_S * 1000 / TICK_MS);
	localparam logic [15:0] RATE_TICKS  = 16'(RATE_S * 1000 / TICK_MS);
	localparam logic [15:0] PROP_TICKS  = 16'(PROP_MS / TICK_MS);
	localparam logic [15:0] BLINK_TICKS = 16'(BLINK_MS / TICK_MS);

	typedef enum logic [1:0] {SEL_BATCH, SEL_CUM, SEL_RATE} view_sel_e;

	// six-digit decimal increment, 999999 wraps to zero
	function automatic logic [23:0] bcd_inc(input logic [23:0] v);
		logic [23:0] r;
		logic        c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction
endpackage

/* File: flow_totalizer_display_control.sv */
// control logic of a battery flow meter: totals, curves, readout, buttons, power
// What this block does
// [R01] flow pulses wake the readout while off
// [R02] view press-and-release wakes readout while off
// [R03] off four minutes after last pulse, blanked
// [R04] view release steps bottom-line selection
// [R05] readout changes on release, not press
// [R06] view held three seconds clears batch
// [R07] batch accumulates volume since last clear
// [R08] cumulative ignores clear, shown with locked flag
// [R09] cumulative wraps after 999999, zero on power
// [R10] calibrate held plus view toggles curve
// [R11] no field calibration means factory curve
// [R12] factory curve shows preset flag
// [R13] rate mode shows rate and rate flag
// [R14] bypass stops counting, shows bypass
// [R15] bypass times out, view reactivates
// [R16] propeller shown while pulses detected
// [R17] error flag shown means no counting
// [R18] top curve, middle flow, bottom totals
// [R19] pulses scaled by active curve to volume
// [R20] failed calibration blinks error flag
// [R21] curves survive power loss, totals do not
// [R22] tick counter times holds, debounced buttons
// [R23] totals kept as decimal counters
`timescale 1ns/100ps
module flow_totalizer_display_control
	import meter_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          ce,
	input  wire logic          pulse_in,
	input  wire logic          view_btn_n,
	input  wire logic          cal_btn_n,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [DW-1:0] rdata,
	output logic               disp_on,
	output logic               preset_flag,
	output logic               field_flag,
	output logic               no_flag,
	output logic      [23:0]   mid_digits,
	output logic               bypass_flag,
	output logic               propeller,
	output logic               total_flag,
	output logic               locked_flag,
	output logic               rate_view_flag
);
	logic [1:0]  pulse_s, view_s, cal_s;
	logic        pulse_d, pulse_rise, sensed;
	logic [31:0] tick_cnt;
	logic        tick;
	logic        view_smp, view_db, view_prev, view_rel;
	logic        cal_smp, cal_db;
	logic [15:0] hold_cnt;
	logic        hold_done, hold_fire;
	logic        on;
	logic [15:0] idle_cnt, idle_lim;
	view_sel_e   sel, next_sel;
	logic        factory_sel, factory_active;
	logic        bypass, rate_feat, cal_mode;
	logic [15:0] k_fac = KFAC_RST;
	logic [15:0] k_fld = KFLD_RST;
	logic        field_valid = 1'b0;
	logic        cal_pass, cal_fail, cal_exit, cal_error;
	logic [15:0] pcnt, k_act;
	logic        count_en, unit;
	logic [23:0] batch, cumul, rate, rate_acc;
	logic [15:0] win_cnt, prop_cnt, blink_cnt;
	logic        blink;
	logic        wr_ctrl;

	// pin synchronisers, buttons inverted to active high
	always_ff @(posedge mclk) begin
		if (reset) begin
			pulse_s <= 2'b00;
			view_s  <= 2'b00;
			cal_s   <= 2'b00;
		end else if (ce) begin
			pulse_s <= {pulse_s[0], pulse_in};
			view_s  <= {view_s[0], ~view_btn_n};
			cal_s   <= {cal_s[0], ~cal_btn_n};
		end
	end

	// pulse edge detect
	always_ff @(posedge mclk) begin
		if (reset) begin
			pulse_d <= 1'b0;
		end else if (ce) begin
			pulse_d <= pulse_s[1];
		end
	end
	assign pulse_rise = pulse_s[1] & ~pulse_d;
	// [R14] bypass stops sensing
	assign sensed = pulse_rise & ~bypass;

	// [R22] fixed-rate tick
	always_ff @(posedge mclk) begin
		if (reset) begin
			tick_cnt <= 32'h0000_0000;
		end else if (ce) begin
			tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end
	assign tick = (tick_cnt == 32'(TICK_CYC - 1));

	// [R22] debounce, value accepted after two equal tick samples
	always_ff @(posedge mclk) begin
		if (reset) begin
			view_smp  <= 1'b0;
			view_db   <= 1'b0;
			cal_smp   <= 1'b0;
			cal_db    <= 1'b0;
			view_prev <= 1'b0;
		end else if (ce) begin
			view_prev <= view_db;
			if (tick) begin
				view_smp <= view_s[1];
				cal_smp  <= cal_s[1];
				if (view_smp == view_s[1])
					view_db <= view_s[1];
				if (cal_smp == cal_s[1])
					cal_db <= cal_s[1];
			end
		end
	end
	// [R05] act on release
	assign view_rel = view_prev & ~view_db;

	// [R06] batch clear after three second hold
	assign hold_fire = view_db && tick && !hold_done && !cal_db && on
		&& sel == SEL_BATCH && hold_cnt == HOLD_TICKS - 16'h0001;
	always_ff @(posedge mclk) begin
		if (reset) begin
			hold_cnt  <= 16'h0000;
			hold_done <= 1'b0;
		end else if (ce) begin
			if (!view_db) begin
				hold_cnt  <= 16'h0000;
				hold_done <= 1'b0;
			end else if (hold_fire) begin
				hold_done <= 1'b1;
			end else if (tick && !hold_done) begin
				hold_cnt <= hold_cnt + 16'h0001;
			end
		end
	end

	// [R15] shorter timeout in bypass
	assign idle_lim = bypass ? BYP_TICKS : OFF_TICKS;

	// power state and idle timeout
	always_ff @(posedge mclk) begin
		if (reset) begin
			on       <= 1'b0;
			idle_cnt <= 16'h0000;
		end else if (ce) begin
			// [R01] [R02] [R15] wake by flow or view release
			if (!on && (sensed || view_rel)) begin
				on       <= 1'b1;
				idle_cnt <= 16'h0000;
			end else if (on) begin
				if (sensed || view_rel) begin
					idle_cnt <= 16'h0000;
				// [R03] self off after timeout
				end else if (tick) begin
					if (idle_cnt >= idle_lim - 16'h0001) begin
						on       <= 1'b0;
						idle_cnt <= 16'h0000;
					end else begin
						idle_cnt <= idle_cnt + 16'h0001;
					end
				end
			end
		end
	end

	// [R04] next bottom-line item
	always_comb begin
		unique case (sel)
			SEL_BATCH: next_sel = SEL_CUM;
			SEL_CUM:   next_sel = rate_feat ? SEL_RATE : SEL_BATCH;
			SEL_RATE:  next_sel = SEL_BATCH;
			default:   next_sel = SEL_BATCH;
		endcase
	end

	// bottom-line selection
	always_ff @(posedge mclk) begin
		if (reset) begin
			sel <= SEL_BATCH;
		end else if (ce) begin
			// [R04] step on plain release
			if (on && view_rel && !cal_db && !hold_done)
				sel <= next_sel;
			else if (sel == SEL_RATE && !rate_feat)
				sel <= SEL_BATCH;
		end
	end

	// curve choice
	always_ff @(posedge mclk) begin
		if (reset) begin
			factory_sel <= 1'b0;
		end else if (ce) begin
			// [R10] shifted view toggles curve
			if (on && view_rel && cal_db)
				factory_sel <= ~factory_sel;
		end
	end
	// [R11] factory until field calibrated
	assign factory_active = factory_sel | ~field_valid;

	// register writes
	assign wr_ctrl  = ce && wr && addr == OFF_CTRL;
	assign cal_pass = ce && wr && addr == OFF_CALRES && wdata[CALRES_PASS];
	assign cal_fail = ce && wr && addr == OFF_CALRES && wdata[CALRES_FAIL];
	assign cal_exit = wr_ctrl && cal_mode && !wdata[CTRL_CAL];
	always_ff @(posedge mclk) begin
		if (reset) begin
			{cal_mode, rate_feat, bypass} <= CTRL_RST;
		end else if (wr_ctrl) begin
			bypass    <= wdata[CTRL_BYPASS];
			rate_feat <= wdata[CTRL_RATE];
			cal_mode  <= wdata[CTRL_CAL];
		end
	end

	// [R21] curves and field-valid kept over reset
	always_ff @(posedge mclk) begin
		if (ce && wr && addr == OFF_KFAC)
			k_fac <= wdata[15:0];
		if (ce && wr && addr == OFF_KFLD)
			k_fld <= wdata[15:0];
		if (cal_pass)
			field_valid <= 1'b1;
	end

	// calibration error flag, a failure wins over a clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			cal_error <= 1'b0;
		// [R20] failed calibration result raises error
		end else if (cal_fail) begin
			cal_error <= 1'b1;
		// [R17] exit or success clears
		end else if (cal_pass || cal_exit) begin
			cal_error <= 1'b0;
		end
	end

	// [R19] pulses per volume unit of active curve
	assign k_act    = factory_active ? k_fac : k_fld;
	// [R17] no counting while error shown
	assign count_en = sensed && !cal_error;
	assign unit     = count_en && (k_act <= 16'h0001 || pcnt >= k_act - 16'h0001);
	always_ff @(posedge mclk) begin
		if (reset) begin
			pcnt <= 16'h0000;
		end else if (ce && count_en) begin
			pcnt <= unit ? 16'h0000 : pcnt + 16'h0001;
		end
	end

	// [R07] [R23] decimal batch total
	always_ff @(posedge mclk) begin
		if (reset) begin
			batch <= BCD_ZERO;
		end else if (ce) begin
			if (hold_fire)
				batch <= unit ? BCD_ONE : BCD_ZERO;
			else if (unit)
				batch <= bcd_inc(batch);
		end
	end

	// [R08] [R09] cumulative ignores clear, wraps
	always_ff @(posedge mclk) begin
		if (reset) begin
			cumul <= BCD_ZERO;
		end else if (ce && unit) begin
			cumul <= bcd_inc(cumul);
		end
	end

	// [R13] volume per minute over one-minute window
	always_ff @(posedge mclk) begin
		if (reset) begin
			rate     <= BCD_ZERO;
			rate_acc <= BCD_ZERO;
			win_cnt  <= 16'h0000;
		end else if (ce) begin
			if (tick && win_cnt == RATE_TICKS - 16'h0001) begin
				win_cnt  <= 16'h0000;
				rate     <= rate_acc;
				rate_acc <= unit ? BCD_ONE : BCD_ZERO;
			end else begin
				if (tick)
					win_cnt <= win_cnt + 16'h0001;
				if (unit)
					rate_acc <= bcd_inc(rate_acc);
			end
		end
	end

	// [R16] propeller hold-off and blink phase
	always_ff @(posedge mclk) begin
		if (reset) begin
			prop_cnt  <= 16'h0000;
			blink_cnt <= 16'h0000;
			blink     <= 1'b0;
		end else if (ce) begin
			if (sensed)
				prop_cnt <= PROP_TICKS;
			else if (tick && prop_cnt != 16'h0000)
				prop_cnt <= prop_cnt - 16'h0001;
			if (tick) begin
				if (blink_cnt == BLINK_TICKS - 16'h0001) begin
					blink_cnt <= 16'h0000;
					blink     <= ~blink;
				end else begin
					blink_cnt <= blink_cnt + 16'h0001;
				end
			end
		end
	end

	// [R18] readout lines, blanked while off
	always_ff @(posedge mclk) begin
		if (reset) begin
			disp_on        <= 1'b0;
			preset_flag    <= 1'b0;
			field_flag     <= 1'b0;
			no_flag        <= 1'b0;
			mid_digits     <= BCD_ZERO;
			bypass_flag    <= 1'b0;
			propeller      <= 1'b0;
			total_flag     <= 1'b0;
			locked_flag    <= 1'b0;
			rate_view_flag <= 1'b0;
		end else if (ce) begin
			disp_on <= on;
			// [R03] blank segments while off
			if (!on) begin
				preset_flag    <= 1'b0;
				field_flag     <= 1'b0;
				no_flag        <= 1'b0;
				mid_digits     <= BCD_ZERO;
				bypass_flag    <= 1'b0;
				propeller      <= 1'b0;
				total_flag     <= 1'b0;
				locked_flag    <= 1'b0;
				rate_view_flag <= 1'b0;
			end else begin
				// [R12] preset on factory curve
				preset_flag    <= factory_active;
				field_flag     <= ~factory_active;
				// [R20] blinking error flag
				no_flag        <= cal_error & blink;
				// [R14] bypass indication on middle line
				bypass_flag    <= bypass;
				// [R16] propeller while flow sensed
				propeller      <= prop_cnt != 16'h0000;
				// [R13] rate shown in middle line
				mid_digits     <= bypass ? BCD_ZERO : sel == SEL_RATE ? rate
					: sel == SEL_CUM ? cumul : batch;
				total_flag     <= sel != SEL_RATE;
				// [R08] locked beside cumulative
				locked_flag    <= sel == SEL_CUM;
				rate_view_flag <= sel == SEL_RATE;
			end
		end
	end

	// register reads, data valid one cycle after strobe
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			rdata <= 32'h0000_0000;
			if (rd) begin
				unique case (addr)
					OFF_CTRL:   rdata <= {29'h0, cal_mode, rate_feat, bypass};
					OFF_STATUS: rdata <= {26'h0, sel, cal_error, field_valid,
						factory_active, on};
					OFF_BATCH:  rdata <= {8'h00, batch};
					OFF_CUMUL:  rdata <= {8'h00, cumul};
					OFF_RATE:   rdata <= {8'h00, rate};
					OFF_KFAC:   rdata <= {16'h0000, k_fac};
					OFF_KFLD:   rdata <= {16'h0000, k_fld};
					default:    rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_flow_wake: // [R01]
		assert property (ce && !on && sensed |=> on)
		else $error("flow pulse did not wake readout");
	a_view_wake: // [R02]
		assert property (ce && !on && view_rel ##1 ce |-> on ##1 disp_on)
		else $error("view release did not wake readout");
	a_off_blank: // [R03]
		assert property (ce && !on |=> !disp_on && mid_digits == BCD_ZERO && !locked_flag)
		else $error("readout not blank while off");
	a_batch_clear: // [R06]
		assert property (ce && hold_fire && !unit |=> batch == BCD_ZERO)
		else $error("batch not cleared by hold");
	a_cumul_locked: // [R08]
		assert property (ce && on && sel == SEL_CUM |=> locked_flag && total_flag)
		else $error("cumulative shown without locked flag");
	a_curve_toggle: // [R10]
		assert property (ce && on && view_rel && cal_db
			|=> factory_sel != $past(factory_sel))
		else $error("curve did not toggle");
	a_preset_show: // [R12]
		assert property (ce && on && factory_active |=> preset_flag)
		else $error("preset flag missing on factory curve");
	a_rate_view: // [R13]
		assert property (ce && on && sel == SEL_RATE && !bypass
			|=> rate_view_flag && mid_digits == $past(rate))
		else $error("rate mode readout wrong");
	a_bypass_hold: // [R14]
		assert property (bypass |=> $stable(cumul))
		else $error("counting during bypass");
	a_error_hold: // [R17]
		assert property (cal_error |=> $stable(cumul) && $stable(pcnt))
		else $error("counting while error flag shown");

	c_batch_clear: cover property (hold_fire ##1 view_rel);
	c_cumul_wrap: cover property (unit && cumul == 24'h99_9999);
	c_curve_toggle: cover property (on && view_rel && cal_db);
	c_timeout_off: cover property (on ##1 !on);
endmodule // flow_totalizer_display_control

/* File: sensor_buttons_model.sv */
// turbine pulse sensor and the two front-panel buttons facing the meter
`timescale 1ns/100ps
module sensor_buttons_model (
	input  wire logic mclk,
	output logic      pulse_in,
	output logic      view_btn_n,
	output logic      cal_btn_n
);
	// idle levels: rotor still, both buttons released on their pull-ups
	initial begin
		pulse_in   = 1'b0;
		view_btn_n = 1'b1;
		cal_btn_n  = 1'b1;
	end

	// n rotor pulses, three cycles high and three low, well above the two-cycle minimum
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge mclk);
			pulse_in <= 1'b1;
			repeat (3) @(posedge mclk);
			pulse_in <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask

	// view button, pressed pulls the pin low
	task automatic view(input logic pressed);
		@(posedge mclk);
		view_btn_n <= ~pressed;
	endtask

	// calibrate button, pressed pulls the pin low
	task automatic cal(input logic pressed);
		@(posedge mclk);
		cal_btn_n <= ~pressed;
	endtask
endmodule // sensor_buttons_model

/* File: flow_totalizer_display_control_tb.sv */
// self-checking bench for the flow totalizer control block
`timescale 1ns/100ps
module flow_totalizer_display_control_tb;
	import meter_pkg::*;
	logic          mclk, reset, ce, pulse_in, view_btn_n, cal_btn_n, wr, rd;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata;
	logic [23:0]   mid_digits;
	logic          disp_on, preset_flag, field_flag, no_flag, bypass_flag;
	logic          propeller, total_flag, locked_flag, rate_view_flag;
	int            bad_count, compares, cycles;

	// short tick so holds and timeouts fit the run
	flow_totalizer_display_control #(.TICK_CYC(4)) i_flow_totalizer_display_control (
		.mclk           (mclk),
		.reset          (reset),
		.ce             (ce),
		.pulse_in       (pulse_in),
		.view_btn_n     (view_btn_n),
		.cal_btn_n      (cal_btn_n),
		.addr           (addr),
		.wdata          (wdata),
		.wr             (wr),
		.rd             (rd),
		.rdata          (rdata),
		.disp_on        (disp_on),
		.preset_flag    (preset_flag),
		.field_flag     (field_flag),
		.no_flag        (no_flag),
		.mid_digits     (mid_digits),
		.bypass_flag    (bypass_flag),
		.propeller      (propeller),
		.total_flag     (total_flag),
		.locked_flag    (locked_flag),
		.rate_view_flag (rate_view_flag)
	);

	sensor_buttons_model i_sensor_buttons_model (
		.mclk(mclk), .pulse_in(pulse_in), .view_btn_n(view_btn_n), .cal_btn_n(cal_btn_n)
	);

	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic flag(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	// one-cycle write strobe
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle only
	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// view press and release, long enough for the debouncer
	task automatic click();
		i_sensor_buttons_model.view(1'b1);
		wt(40);
		i_sensor_buttons_model.view(1'b0);
		wt(40);
	endtask

	task automatic curve_toggle();
		i_sensor_buttons_model.cal(1'b1);
		wt(40);
		click();
		i_sensor_buttons_model.cal(1'b0);
		wt(40);
	endtask

	task automatic done(input string name);
		$display("test %s finished, mismatches so far %0d", name, bad_count);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard, the tests need about 74000 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			bad_count++;
			$display("ERROR at %0t: run timed out", $time);
			report_and_stop();
		end
	end

	// main sequence
	initial begin
		{reset, ce, wr, rd, addr, wdata} = {1'b1, 1'b1, 2'b00, 8'h00, 32'h0000_0000};
		cycles    = 0;
		bad_count = 0;
		compares  = 0;
		wt(16);
		reset <= 1'b0;
		wt(2);
		// blank readout and register reset values
		flag(disp_on, 1'b0);
		chk({8'h00, mid_digits}, 32'h0000_0000);
		rd_chk(OFF_CTRL, 32'h0000_0000);
		rd_chk(OFF_KFAC, {16'h0000, KFAC_RST});
		rd_chk(OFF_KFLD, {16'h0000, KFLD_RST});
		rd_chk(8'h40, 32'h0000_0000);
		wr_reg(OFF_KFAC, 32'h0000_0001);
		wr_reg(OFF_KFLD, 32'h0000_0002);
		wr_reg(OFF_BATCH, 32'h0012_3456);
		done("reset");
		// flow wakes the meter and counts with the factory curve
		i_sensor_buttons_model.pulses(12);
		wt(10);
		flag(disp_on, 1'b1);
		flag(propeller, 1'b1);
		flag(preset_flag, 1'b1);
		flag(total_flag, 1'b1);
		rd_chk(OFF_BATCH, 32'h0000_0012);
		rd_chk(OFF_CUMUL, 32'h0000_0012);
		chk({8'h00, mid_digits}, 32'h0000_0012);
		done("wake_count");
		// calibration error blocks counting until a pass
		wr_reg(OFF_CALRES, 32'h0000_0002);
		for (int i = 0; i < 400 && no_flag !== 1'b1; i++) begin
			@(posedge mclk);
		end
		flag(no_flag, 1'b1);
		i_sensor_buttons_model.pulses(4);
		wt(10);
		rd_chk(OFF_BATCH, 32'h0000_0012);
		wr_reg(OFF_CALRES, 32'h0000_0001);
		wt(5);
		flag(no_flag, 1'b0);
		done("cal_error");
		// curve toggle with calibrate held, ending on the field curve
		flag(preset_flag, 1'b0);
		curve_toggle();
		flag(preset_flag, 1'b1);
		curve_toggle();
		flag(preset_flag, 1'b0);
		flag(field_flag, 1'b1);
		rd_chk(OFF_STATUS, 32'h0000_0005);
		i_sensor_buttons_model.pulses(4);
		wt(10);
		rd_chk(OFF_BATCH, 32'h0000_0014);
		done("curves");
		// clock enable low freezes the block, pulses in that time are lost
		@(posedge mclk);
		ce <= 1'b0;
		i_sensor_buttons_model.pulses(4);
		wt(5);
		ce <= 1'b1;
		wt(5);
		rd_chk(OFF_BATCH, 32'h0000_0014);
		flag(disp_on, 1'b1);
		done("clock_enable");
		// bottom-line stepping happens on release
		wr_reg(OFF_CTRL, 32'h0000_0002);
		i_sensor_buttons_model.view(1'b1);
		wt(40);
		flag(locked_flag, 1'b0);
		i_sensor_buttons_model.view(1'b0);
		wt(40);
		flag(locked_flag, 1'b1);
		chk({8'h00, mid_digits}, 32'h0000_0014);
		click();
		flag(rate_view_flag, 1'b1);
		chk({8'h00, mid_digits}, 32'h0000_0000);
		click();
		flag(rate_view_flag, 1'b0);
		flag(locked_flag, 1'b0);
		done("steps");
		// three-second hold clears only the batch total
		i_sensor_buttons_model.view(1'b1);
		wt(1300);
		chk({8'h00, mid_digits}, 32'h0000_0000);
		rd_chk(OFF_BATCH, 32'h0000_0000);
		i_sensor_buttons_model.view(1'b0);
		wt(40);
		flag(locked_flag, 1'b0);
		flag(propeller, 1'b0);
		rd_chk(OFF_CUMUL, 32'h0000_0014);
		done("clear");
		// bypass ignores flow, shows its flag and times out
		wr_reg(OFF_CTRL, 32'h0000_0003);
		i_sensor_buttons_model.pulses(4);
		wt(10);
		flag(bypass_flag, 1'b1);
		chk({8'h00, mid_digits}, 32'h0000_0000);
		rd_chk(OFF_CUMUL, 32'h0000_0014);
		wt(70000);
		flag(disp_on, 1'b1);
		for (int i = 0; i < 3000 && disp_on !== 1'b0; i++) begin
			@(posedge mclk);
		end
		flag(disp_on, 1'b0);
		flag(bypass_flag, 1'b0);
		click();
		flag(disp_on, 1'b1);
		done("bypass");
		// mid-run reset zeroes totals but keeps curves and field state
		@(posedge mclk);
		reset <= 1'b1;
		wt(4);
		reset <= 1'b0;
		wt(2);
		flag(disp_on, 1'b0);
		rd_chk(OFF_CUMUL, 32'h0000_0000);
		rd_chk(OFF_KFAC, 32'h0000_0001);
		rd_chk(OFF_STATUS, 32'h0000_0004);
		done("power");
		report_and_stop();
	end
endmodule // flow_totalizer_display_control_tb
